// [rtl/cpm_defs.svh]
/*
 Constants for the per-core power-mode handshake block.
 Assumes inclusion by bare name from rtl/.
*/
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH
`define CPM_PSTATE_W 2
`define CPM_PSTATE_RST 2'h0
`define CPM_CORES 4
`define CPM_RAM_DOMAINS 5
`define CPM_DOMAINS 14
`define CPM_CE_IDLE 1'h0
`endif

// [rtl/cpm_pkg.sv]
/*
 Types for the power-mode handshake block.
 Assumes cpm_defs.svh is visible.
*/
`include "cpm_defs.svh"
package cpm_pkg;
   typedef enum {
      CPM_RUN, CPM_DRAIN_WFI, CPM_DRAIN_WFE, CPM_WFI, CPM_WFE
   } cpm_mode_t;
   typedef logic [`CPM_PSTATE_W-1:0] cpm_pstate_t;
endpackage : cpm_pkg

// [rtl/cpm_wake_sync.sv]
/*
 Two-stage synchroniser for asynchronous inputs.
 Assumes one destination clock.
*/
`timescale 1ns/1ps
module cpm_wake_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : cpm_wake_sync

// [rtl/cpm_core_power.sv]
/*
 Per-core power-mode logic: run, interrupt-wait and event-wait standby, wake
 detection, power state publication and domain isolation status.
 Assumes an external power controller drives reset, clamps and power.
*/
`timescale 1ns/1ps
`include "cpm_defs.svh"
module cpm_core_power (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic exec_wfi,
   input wire logic exec_wfe,
   input wire logic mem_busy,
   input wire logic irq_any,
   input wire logic irq_unmasked,
   input wire logic imprecise_abort,
   input wire logic external_debug_request,
   input wire logic debug_halt_cmd,
   input wire logic maint_req,
   input wire logic exc_return,
   input wire logic event_wake_in,
   input wire logic send_event,
   input wire logic snoop_req,
   input wire logic debug_bus_req,
   input wire cpm_pkg::cpm_pstate_t power_status,
   input wire logic debug_domain_isolate,
   input wire logic [`CPM_CORES-1:0] core_domain_isolate,
   input wire logic [`CPM_CORES-1:0] vector_engine_isolate,
   input wire logic [`CPM_RAM_DOMAINS-1:0] ram_domain_isolate,
   output logic core_clk_en,
   output logic l1_clk_en,
   output logic debug_clk_en,
   output logic standby_indication,
   output logic standby_event,
   output logic wake_pulse,
   output logic ram_chip_enable,
   output logic [`CPM_DOMAINS-1:0] domain_isolated,
   output cpm_pkg::cpm_pstate_t power_state_out
);
   import cpm_pkg::*;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [3:0] async_raw;
   logic [3:0] async_s;
   assign async_raw = {external_debug_request, event_wake_in, irq_any, irq_unmasked};
   cpm_wake_sync #(.W(4)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d(async_raw),
      .q(async_s)
   );
   wire dbg_req_s = async_s[3];
   wire event_s = async_s[2];
   wire irq_any_s = async_s[1];
   wire irq_unm_s = async_s[0];

   // ----------------------------------------
   // Wake decode
   // ----------------------------------------
   wire debug_wake = dbg_req_s | debug_halt_cmd;
   wire wfi_wake = irq_any_s | imprecise_abort | debug_wake | maint_req;
   wire wfe_wake = irq_unm_s | debug_wake | maint_req | exc_return
                   | event_s | send_event;

   cpm_mode_t mode;
   cpm_mode_t next_mode;
   always_comb begin
      next_mode = mode;
      case (mode)
         CPM_RUN: begin
            if (exec_wfi) begin
               next_mode = CPM_DRAIN_WFI;
            end else if (exec_wfe) begin
               next_mode = CPM_DRAIN_WFE;
            end
         end
         CPM_DRAIN_WFI: begin
            if (wfi_wake) next_mode = CPM_RUN;
            else if (!mem_busy) next_mode = CPM_WFI;
         end
         CPM_DRAIN_WFE: begin
            if (wfe_wake) next_mode = CPM_RUN;
            else if (!mem_busy) next_mode = CPM_WFE;
         end
         CPM_WFI: begin
            if (wfi_wake) next_mode = CPM_RUN;
         end
         CPM_WFE: begin
            if (wfe_wake) next_mode = CPM_RUN;
         end
         default: next_mode = CPM_RUN;
      endcase
   end

   wire in_standby = (next_mode == CPM_WFI) || (next_mode == CPM_WFE);
   wire leaving = ((mode == CPM_WFI) || (mode == CPM_WFE)) && (next_mode == CPM_RUN);
   wire [`CPM_DOMAINS-1:0] iso_vec = {ram_domain_isolate, vector_engine_isolate,
                                      core_domain_isolate, debug_domain_isolate};

   // ----------------------------------------
   // State and registered outputs
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode <= CPM_RUN;
         core_clk_en <= 1'h1;
         l1_clk_en <= 1'h1;
         debug_clk_en <= 1'h1;
         standby_indication <= 1'h0;
         standby_event <= 1'h0;
         wake_pulse <= 1'h0;
         ram_chip_enable <= `CPM_CE_IDLE;
         domain_isolated <= '0;
         power_state_out <= `CPM_PSTATE_RST;
      end else begin
         mode <= next_mode;
         core_clk_en <= !in_standby;
         l1_clk_en <= !in_standby || snoop_req;
         debug_clk_en <= 1'h1 || debug_bus_req;
         standby_indication <= (next_mode == CPM_WFI);
         standby_event <= (next_mode == CPM_WFE);
         wake_pulse <= leaving;
         ram_chip_enable <= !iso_vec[`CPM_DOMAINS-1] && !in_standby;
         domain_isolated <= iso_vec;
         if (standby_indication && mode == CPM_WFI) begin
            power_state_out <= power_status;
         end
      end
   end

   // ----------------------------------------
   // Checks: clocking and RAM chip enable per mode
   // ----------------------------------------
   standby_clk_a: assert property (
      @(posedge core_clk) disable iff (rst)
      standby_indication |-> !core_clk_en)
      else $error("core clock running in standby");

   event_clk_a: assert property (
      @(posedge core_clk) disable iff (rst)
      standby_event |-> !core_clk_en)
      else $error("core clock running in event standby");

   run_clk_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_RUN && $past(mode) == CPM_RUN) |-> core_clk_en)
      else $error("core clock off in run");

   ram_ce_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (standby_indication || standby_event) |-> !ram_chip_enable)
      else $error("ram enabled in standby");

   debug_clk_a: assert property (
      @(posedge core_clk) disable iff (rst)
      standby_indication |-> debug_clk_en)
      else $error("debug clock stopped");

   snoop_wake_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (snoop_req && in_standby) |=> (l1_clk_en && !core_clk_en))
      else $error("snoop wake wrong");

   // ----------------------------------------
   // Checks: entry and wake-up
   // ----------------------------------------
   wfx_entry_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_RUN && !exec_wfi && !exec_wfe) |=> mode == CPM_RUN)
      else $error("standby without instruction");

   standby_excl_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !(standby_indication && standby_event))
      else $error("both standby kinds shown");

   wfi_drain_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_DRAIN_WFI && mem_busy) |=> mode != CPM_WFI)
      else $error("standby before accesses done");

   wfe_drain_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_DRAIN_WFE && mem_busy) |=> mode != CPM_WFE)
      else $error("event standby before accesses done");

   wfi_wake_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_WFI && wfi_wake) |=> mode == CPM_RUN)
      else $error("missed interrupt-wait wake");

   wfe_wake_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_WFE && wfe_wake) |=> mode == CPM_RUN)
      else $error("missed event-wait wake");

   dbg_wake_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_WFI && debug_halt_cmd) |=> mode == CPM_RUN)
      else $error("halt command did not wake");

   wfe_dbg_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode == CPM_WFE && debug_halt_cmd) |=> mode == CPM_RUN)
      else $error("halt command did not wake event wait");

   wake_pulse_a: assert property (
      @(posedge core_clk) disable iff (rst)
      wake_pulse |=> !wake_pulse)
      else $error("wake pulse longer than one cycle");

   wake_run_a: assert property (
      @(posedge core_clk) disable iff (rst)
      wake_pulse |-> (core_clk_en && !standby_indication && !standby_event))
      else $error("wake without run clock");

   // ----------------------------------------
   // Checks: power state, isolation, reset
   // ----------------------------------------
   pstate_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !(standby_indication && mode == CPM_WFI) |=> $stable(power_state_out))
      else $error("power state changed early");

   pstate_load_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (standby_indication && mode == CPM_WFI) |=> power_state_out == $past(power_status))
      else $error("power state not loaded");

   iso_report_a: assert property (
      @(posedge core_clk) disable iff (rst)
      1'h1 |=> domain_isolated == $past(iso_vec))
      else $error("isolation status wrong");

   // Not disabled by reset: checks what reset leaves behind
   reset_run_a: assert property (
      @(posedge core_clk)
      rst |=> (mode == CPM_RUN && core_clk_en && !standby_indication))
      else $error("reset did not return to run");
endmodule : cpm_core_power

// [verification/cpm_pwr_ctrl.sv]
/* Power controller model: clamps, cuts power, holds core reset, restores.
 Assumes the core's standby and power state outputs on core_clk. */
`timescale 1ns/1ps
module cpm_pwr_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic standby_indication,
   input wire cpm_pkg::cpm_pstate_t power_state_out,
   input wire logic wake_req,
   output logic iso,
   output logic powered,
   output logic ctrl_rst
);
   import cpm_pkg::*;
   logic [2:0] step;
   // Steps: 1 clamp, 2 off, 3 reset, 4 hold, 5 on, 6 unclamp next, 7 reset only
   always_ff @(posedge core_clk) begin
      if (rst) step <= 3'h0;
      else if (step == 3'h0) step <= {2'h0, standby_indication && power_state_out == 2'h2};
      else if (step != 3'h4 || wake_req) step <= step + 3'h1;
   end
   assign iso = step != 3'h0 && step != 3'h7;
   assign powered = step < 3'h2 || step > 3'h4;
   assign ctrl_rst = step > 3'h2;
endmodule : cpm_pwr_ctrl

// [verification/cpm_core_power_tb.sv]
/* Self-checking bench for the per-core power-mode block.
 Assumes the controller model drives clamps and core reset. */
`timescale 1ns/1ps
module cpm_core_power_tb;
   import cpm_pkg::*;
   logic core_clk = 0, tb_rst = 1, exec_wfi = 0, exec_wfe = 0, mem_busy = 0, snoop_req = 0;
   logic wake_req = 0;
   logic [8:0] src = 9'h0;
   cpm_pstate_t ps = 2'h1;
   int failures = 0, n_checks = 0, k;
   logic core_clk_en, l1_clk_en, debug_clk_en, standby_indication, standby_event, wake_pulse;
   logic ram_chip_enable, iso, powered, ctrl_rst;
   logic [13:0] domain_isolated;
   cpm_pstate_t power_state_out;
   logic [8:0] wfi_m [5] = '{9'h001, 9'h004, 9'h008, 9'h010, 9'h020};
   logic [8:0] wfe_m [7] = '{9'h003, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100};
   cpm_core_power dut (.core_clk(core_clk), .rst(tb_rst | ctrl_rst), .exec_wfi(exec_wfi),
      .exec_wfe(exec_wfe), .mem_busy(mem_busy), .irq_any(src[0]), .irq_unmasked(src[1]),
      .imprecise_abort(src[2]), .external_debug_request(src[3]), .debug_halt_cmd(src[4]),
      .maint_req(src[5]), .exc_return(src[6]), .event_wake_in(src[7]), .send_event(src[8]),
      .snoop_req(snoop_req), .debug_bus_req(1'h0), .power_status(ps),
      .debug_domain_isolate(iso), .core_domain_isolate({4{iso}}),
      .vector_engine_isolate({4{iso}}), .ram_domain_isolate({5{iso}}),
      .core_clk_en(core_clk_en), .l1_clk_en(l1_clk_en), .debug_clk_en(debug_clk_en),
      .standby_indication(standby_indication), .standby_event(standby_event),
      .wake_pulse(wake_pulse), .ram_chip_enable(ram_chip_enable),
      .domain_isolated(domain_isolated), .power_state_out(power_state_out));
   cpm_pwr_ctrl ctrl (.core_clk(core_clk), .rst(tb_rst), .standby_indication(standby_indication),
      .power_state_out(power_state_out), .wake_req(wake_req), .iso(iso),
      .powered(powered), .ctrl_rst(ctrl_rst));
   initial forever #12.5 core_clk = ~core_clk;
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin failures++; $display("[ERR] %0t %s", $time, m); end
   endtask : chk
   task automatic go(input logic wait_for_event);
      @(negedge core_clk);
      exec_wfi = !wait_for_event;
      exec_wfe = wait_for_event;
      @(negedge core_clk);
      {exec_wfi, exec_wfe} = 2'h0;
   endtask : go
   task automatic sb(input logic wait_for_event);
      int i;
      for (i = 0; i < 10 && {standby_event, standby_indication} != {wait_for_event, !wait_for_event}; i++)
         @(negedge core_clk);
      chk({standby_event, standby_indication, core_clk_en} === {wait_for_event, !wait_for_event, 1'b0}, "standby");
   endtask : sb
   task automatic wake(input logic [8:0] m);
      int i;
      logic seen;
      seen = 0;
      src = m;
      for (i = 0; i < 8 && core_clk_en !== 1'b1; i++) begin
         @(negedge core_clk);
         seen |= wake_pulse;
      end
      src = 9'h0;
      chk(core_clk_en === 1'b1 && seen && {standby_event, standby_indication} === 2'h0, "wake");
      repeat (4) @(negedge core_clk);
   endtask : wake
   task automatic end_sim;
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(negedge core_clk);
      tb_rst = 0;
      repeat (3) @(negedge core_clk);
      chk({core_clk_en, l1_clk_en, debug_clk_en, ram_chip_enable} === 4'hf, "run");
      chk(power_state_out === 2'h0 && domain_isolated === 14'h0, "rst vals");
      mem_busy = 1;
      go(0);
      repeat (5) @(negedge core_clk);
      chk(standby_indication === 1'b0, "early standby");
      mem_busy = 0;
      sb(0);
      chk(power_state_out === 2'h0, "early pstate");
      @(negedge core_clk);
      chk(power_state_out === ps && debug_clk_en === 1'b1, "pstate");
      snoop_req = 1;
      @(negedge core_clk);
      chk(l1_clk_en === 1'b1 && core_clk_en === 1'b0, "snoop");
      snoop_req = 0;
      wake(9'h004);
      for (k = 0; k < 5; k++) begin go(0); sb(0); wake(wfi_m[k]); end
      go(1);
      sb(1);
      src = 9'h001;
      repeat (6) @(negedge core_clk);
      chk(standby_event === 1'b1, "masked irq woke");
      wake(9'h080);
      for (k = 0; k < 7; k++) begin go(1); sb(1); wake(wfe_m[k]); end
      ps = 2'h2;
      go(0);
      sb(0);
      for (k = 0; k < 12 && powered !== 1'b0; k++) @(negedge core_clk);
      chk(domain_isolated === 14'h3fff && ram_chip_enable === 1'b0, "clamp");
      for (k = 0; k < 12 && ctrl_rst !== 1'b1; k++) @(negedge core_clk);
      ps = 2'h1;
      wake_req = 1;
      for (k = 0; k < 12 && ctrl_rst !== 1'b0; k++) @(negedge core_clk);
      wake_req = 0;
      repeat (3) @(negedge core_clk);
      chk(core_clk_en === 1'b1 && power_state_out === 2'h0, "restore");
      end_sim;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      failures++;
      end_sim;
   end
endmodule : cpm_core_power_tb
